// [tsf_map.vh]
// Purpose: constants for the touch controller serial slave framing
// Assumes: mode 0 serial port, sampled by a 200 MHz system clock
// Notes:   definitions only
`ifndef TSF_MAP_VH
`define TSF_MAP_VH
`define TSF_SYNC_STAGES    3
`define TSF_BYTE_BITS      8
`define TSF_SHORT_CLOCKS   8
`define TSF_LONG_CLOCKS    24
`define TSF_CNT_W          5
`define TSF_CMD_BIT        7
`endif

// [tsf_sync.v]
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: input is asynchronous to clk
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module tsf_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst_n,
  input  wire pin,
  output reg  level_ff
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff    <= RESET_VAL;
      s2_ff    <= RESET_VAL;
      s3_ff    <= RESET_VAL;
      level_ff <= RESET_VAL;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end
endmodule
`default_nettype wire

// [tsf_spi_slave.v]
// Purpose: serial slave framing for a touch screen controller port
// Assumes: host is mode 0 master; clk far faster than the serial clock
// Notes:   command bit 7 set selects short form, clear selects long form
`timescale 1ns/1ps
`default_nettype none
`include "tsf_map.vh"
module tsf_spi_slave #(
  parameter LONG_CLOCKS  = `TSF_LONG_CLOCKS,
  parameter SHORT_CLOCKS = `TSF_SHORT_CLOCKS
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        sclk_pin,
  input  wire        cs_n_pin,
  input  wire        serial_in_pin,
  output reg         serial_out_pin,
  output wire        serial_out_oe_n,
  input  wire [15:0] rd_data,
  output reg         short_done_ff,
  output reg  [7:0]  short_cmd_ff,
  output reg         long_done_ff,
  output reg  [7:0]  long_cmd_ff,
  output reg  [15:0] long_data_ff,
  output reg         rd_req_ff,
  output reg  [7:0]  rd_addr_ff
);
  // framing machine states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CMD  = 2'h1;
  localparam [1:0] ST_LONG = 2'h2;

  // synchroniser bank order: clock, select, data
  localparam       PIN_N   = 3;
  // select resets high so no frame is seen during reset
  localparam [2:0] PIN_RST = 3'h2;

  // cycle lengths cut to the counter width on purpose
  localparam [`TSF_CNT_W-1:0] SHORT_END = SHORT_CLOCKS;
  localparam [`TSF_CNT_W-1:0] LONG_END  = LONG_CLOCKS;

  wire [PIN_N-1:0]      pin_raw;
  wire [PIN_N-1:0]      pin_s;
  wire                  sclk_s;
  wire                  cs_n_s;
  wire                  sdi_s;
  wire                  rise;
  wire                  fall;
  wire                  in_cmd;
  wire                  in_long;
  wire                  cmd_short;
  wire                  short_end;
  wire                  long_end;
  wire [23:0]           nxt_shift;
  wire [`TSF_CNT_W-1:0] cnt_inc;
  reg                   sclk_d_ff;
  reg                   active_ff;
  reg  [1:0]            state_ff;
  reg  [1:0]            nxt_state;
  reg  [`TSF_CNT_W-1:0] cnt_ff;
  reg  [`TSF_CNT_W-1:0] nxt_cnt;
  reg  [23:0]           shift_ff;
  reg  [15:0]           tx_ff;

  // true when the incremented count closes a cycle of that length
  function cycle_end;
    input [`TSF_CNT_W-1:0] count;
    input [`TSF_CNT_W-1:0] limit;
    begin
      cycle_end = (count == limit);
    end
  endfunction

  assign pin_raw = {serial_in_pin, cs_n_pin, sclk_pin};

  // each pin crosses from the host side through its own filter
  genvar g;
  generate
    for (g = 0; g < PIN_N; g = g + 1) begin : gen_sync
      tsf_sync #(
        .RESET_VAL (PIN_RST[g])
      ) tsf_sync_i (
        .clk      (clk),
        .rst_n    (rst_n),
        .pin      (pin_raw[g]),
        .level_ff (pin_s[g])
      );
    end
  endgenerate

  // clock and data share one latency, so data lines up with its edge
  assign sclk_s = pin_s[0];
  assign cs_n_s = pin_s[1];
  assign sdi_s  = pin_s[2];

  // idle-low clock: rise is capture, fall is launch
  assign rise      = sclk_s & ~sclk_d_ff & ~cs_n_s;
  assign fall      = ~sclk_s & sclk_d_ff & ~cs_n_s;
  assign nxt_shift = {shift_ff[22:0], sdi_s};
  assign cnt_inc   = cnt_ff + {{(`TSF_CNT_W-1){1'b0}}, 1'b1};
  assign in_cmd    = (state_ff == ST_IDLE) | (state_ff == ST_CMD);
  assign in_long   = (state_ff == ST_LONG);
  assign cmd_short = nxt_shift[`TSF_CMD_BIT];
  assign short_end = cycle_end(cnt_inc, SHORT_END);
  assign long_end  = cycle_end(cnt_inc, LONG_END);
  assign serial_out_oe_n = ~active_ff;

  // next state and count; the count steps only on a capture edge and clears on deselect
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (cs_n_s) begin
      // partial cycle dropped on deselect
      nxt_state = ST_IDLE;
      nxt_cnt   = {`TSF_CNT_W{1'b0}};
    end else begin
      if (state_ff == ST_IDLE) begin
        nxt_state = ST_CMD;
      end
      if (rise) begin
        nxt_cnt = cnt_inc;
        case (state_ff)
          ST_IDLE,
          ST_CMD: begin
            if (short_end) begin
              if (cmd_short) begin
                nxt_cnt   = {`TSF_CNT_W{1'b0}};
                nxt_state = ST_CMD;
              end else begin
                nxt_state = ST_LONG;
              end
            end
          end
          ST_LONG: begin
            if (long_end) begin
              nxt_cnt   = {`TSF_CNT_W{1'b0}};
              nxt_state = ST_CMD;
            end
          end
          default: begin
            nxt_state = ST_IDLE;
          end
        endcase
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_ff <= 1'b0;
      active_ff <= 1'b0;
      state_ff  <= ST_IDLE;
      cnt_ff    <= {`TSF_CNT_W{1'b0}};
      shift_ff  <= 24'h000000;
    end else begin
      sclk_d_ff <= sclk_s;
      active_ff <= ~cs_n_s;
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      if (rise) begin
        shift_ff <= nxt_shift;
      end
    end
  end

  // one-cycle strobes; data registers hold until the next completion
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      short_done_ff <= 1'b0;
      short_cmd_ff  <= 8'h00;
      long_done_ff  <= 1'b0;
      long_cmd_ff   <= 8'h00;
      long_data_ff  <= 16'h0000;
      rd_req_ff     <= 1'b0;
      rd_addr_ff    <= 8'h00;
    end else begin
      short_done_ff <= 1'b0;
      long_done_ff  <= 1'b0;
      rd_req_ff     <= 1'b0;
      if (rise && in_cmd && short_end) begin
        if (cmd_short) begin
          short_done_ff <= 1'b1;
          short_cmd_ff  <= nxt_shift[7:0];
        end else begin
          // fetch read word before first data bit launches
          rd_req_ff   <= 1'b1;
          rd_addr_ff  <= nxt_shift[7:0];
          long_cmd_ff <= nxt_shift[7:0];
        end
      end
      if (rise && in_long && long_end) begin
        long_done_ff <= 1'b1;
        long_data_ff <= nxt_shift[15:0];
      end
    end
  end

  // output shifter; a fast host clock leaves no time for the fetch
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ff          <= 16'h0000;
      serial_out_pin <= 1'b0;
    end else if (cs_n_s) begin
      serial_out_pin <= 1'b0;
    end else begin
      if (rd_req_ff) begin
        tx_ff <= rd_data;
      end
      if (fall) begin
        if (in_long) begin
          serial_out_pin <= tx_ff[15];
          tx_ff          <= {tx_ff[14:0], 1'b0};
        end else begin
          serial_out_pin <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tsf_spi_slave_monitor.sv]
// Purpose: port checks on tsf_spi_slave
// Assumes: 200 MHz clk, 64 ns serial clock
// Notes: windows allow for the pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module tsf_spi_slave_monitor (
  input wire clk,
  input wire rst_n,
  input wire sclk_pin,
  input wire cs_n_pin,
  input wire serial_out_pin,
  input wire serial_out_oe_n,
  input wire short_done_ff,
  input wire long_done_ff,
  input wire rd_req_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sel_idle_a: assert property ($fell(serial_out_oe_n) |->
    !cs_n_pin && !sclk_pin) else $error("drive not at idle");
  out_fall_a: assert property (!serial_out_oe_n &&
    $changed(serial_out_pin) |-> !sclk_pin) else $error("out edge");
  req_sel_a: assert property (rd_req_ff |-> !cs_n_pin)
    else $error("req unselected");
  short_one_a: assert property (short_done_ff |=>
    !short_done_ff && !long_done_ff) else $error("short pulse");
  long_gap_a: assert property (rd_req_ff |-> ##[195:215]
    long_done_ff) else $error("long span");
  long_sel_a: assert property (long_done_ff |->
    !cs_n_pin && !rd_req_ff) else $error("long done");
  out_float_a: assert property ($rose(cs_n_pin) |-> ##[1:8]
    serial_out_oe_n) else $error("no float");
endmodule
bind tsf_spi_slave tsf_spi_slave_monitor tsf_spi_slave_monitor_i (.clk,
  .rst_n, .sclk_pin, .cs_n_pin, .serial_out_pin, .serial_out_oe_n,
  .short_done_ff, .long_done_ff, .rd_req_ff);
`default_nettype wire

// [tsf_host_model.sv]
// Purpose: mode 0 host master model
// Assumes: 64 ns serial clock
// Notes: data line toggles once released
`timescale 1ns/1ps
`default_nettype none
module tsf_host_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input  wire  miso
);
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h0;
  end
  task automatic xfer(input int n, input logic [23:0] d,
                      output logic [23:0] q);
    q = 24'h0;
    cs_n = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = d[i];
      #32 sclk = 1'h1;
      q[i] = miso;
      #32 sclk = 1'h0;
    end
  endtask
  task automatic end_frame;
    #32 cs_n = 1'h1;
    mosi = ~mosi;
    #64;
  endtask
endmodule
`default_nettype wire

// [tsf_spi_slave_tb.sv]
// Purpose: bench for tsf_spi_slave
// Assumes: host model drives the serial pins
// Notes: done pulses are counted per clock
`timescale 1ns/1ps
`default_nettype none
module tsf_spi_slave_tb;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [15:0] rd_data = 16'h0;
  logic [23:0] q, ns = 24'h0, nl = 24'h0, nr = 24'h0;
  int          err_count = 0, cmp_count = 0, cyc = 0;
  wire         sclk, cs_n, mosi, miso, miso_ln, oe_n, sd, ld, rq;
  wire  [7:0]  sc, lc, ra;
  wire  [15:0] dat;
  initial forever #2.5 clk = ~clk;
  // a released line reads back inverted, so a stray sample shows
  assign miso_ln = oe_n ? ~miso : miso;
  tsf_host_model tsf_host_model_i (.sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso_ln));
  tsf_spi_slave tsf_spi_slave_i (.clk(clk), .rst_n(rst_n),
    .sclk_pin(sclk), .cs_n_pin(cs_n), .serial_in_pin(mosi),
    .serial_out_pin(miso), .serial_out_oe_n(oe_n), .rd_data(rd_data),
    .short_done_ff(sd), .short_cmd_ff(sc), .long_done_ff(ld),
    .long_cmd_ff(lc), .long_data_ff(dat), .rd_req_ff(rq),
    .rd_addr_ff(ra));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ns <= ns + sd;
    nl <= nl + ld;
    nr <= nr + rq;
    if (cyc == 4000) begin
      err_count++;
      stop_test;
    end
  end
  task automatic chk(input string n, input logic [23:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_short;
    tsf_host_model_i.xfer(8, 24'hC3, q);
    tsf_host_model_i.end_frame;
    chk("short_cmd", sc, 8'hC3);
    chk("short_n", ns, 24'h1);
    chk("oe_n", oe_n, 1'h1);
  endtask
  task automatic t_long;
    @(posedge clk);
    #1.5 rd_data = 16'hB4E1;
    tsf_host_model_i.xfer(24, 24'h359C6A, q);
    tsf_host_model_i.end_frame;
    chk("rd_addr", ra, 8'h35);
    chk("long_data", dat, 16'h9C6A);
    chk("out_word", q[15:0], 16'hB4E1);
    chk("long_n", nl, 24'h1);
  endtask
  task automatic t_b2b;
    tsf_host_model_i.xfer(8, 24'h81, q);
    tsf_host_model_i.xfer(24, 24'h120F0F, q);
    tsf_host_model_i.end_frame;
    chk("b2b_short", sc, 8'h81);
    chk("b2b_data", dat, 16'h0F0F);
    chk("b2b_n", nl, 24'h2);
  endtask
  task automatic t_abort;
    tsf_host_model_i.xfer(5, 24'h0A, q);
    tsf_host_model_i.end_frame;
    chk("abort_req", nr, 24'h2);
    tsf_host_model_i.xfer(24, 24'h2A5533, q);
    tsf_host_model_i.end_frame;
    chk("abort_cmd", lc, 8'h2A);
    chk("abort_data", dat, 16'h5533);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1.5 rst_n = 1'h1;
    repeat (8) @(posedge clk);
    // 1.5 ns offset keeps host edges off the sampling edges
    #1.5;
    t_short;
    t_long;
    t_b2b;
    t_abort;
    stop_test;
  end
endmodule
`default_nettype wire
